/* File: verilog/sds_access.sv */
/*
 * special-data store access: mode entry through mode register three,
 * page and format selection, page 0 patterns, error log and setting
 * readout pages, and an eight- or chopped four-unit-interval read burst after latency.
 * assumes a decoded command stream, one command per sys_clk, on the
 * device clock; controller obeys the command limits of the mode.
 */
`timescale 1ns/100ps
// Behaviour
// - four pages of four byte locations
// - pages 1-3 read only serially
// - mode bit two enables store access
// - bits 12:11 pick readout format
// - bits 1:0 pick active page
// - auto precharge variants behave as plain
// - never invert read data here
// - bit seven leaves first, bit zero last (chop sends bits 7:4 or 3:0 here)
// - bank bits select location (parallel page 0 reads location 0 here); page 0 defaults
// - vendor page undefined except location 3 low
// - page 2 loc 0 reports refresh rate
// - fixed burst eight or chop four
// - page 0 keeps writes until reset
// - burst after additive plus CAS latency
module sds_access (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// decoded command bus
	input  wire logic        cmd_valid,
	input  wire logic [3:0]  cmd_code,
	input  wire logic [17:0] cmd_addr,
	input  wire logic [1:0]  cmd_bank,
	input  wire logic [1:0]  cmd_group,
	input  wire logic        cmd_chop,
	// latency and setting inputs from the mode logic
	input  wire logic [4:0]  add_latency,
	input  wire logic [4:0]  cas_latency,
	input  wire logic [1:0]  refresh_rate,
	input  wire logic [7:0]  setting_byte_1,
	input  wire logic [7:0]  setting_byte_2,
	input  wire logic [7:0]  setting_byte_3,
	input  wire logic [2:0]  setting_byte_0_rest,
	input  wire logic [2:0]  setting_byte_0_low,
	// error capture from the parity and crc checkers
	input  wire logic        err_cap,
	input  wire logic        err_par_bit,
	input  wire logic        err_act_n,
	input  wire logic        crc_err,
	input  wire logic        parity_err,
	input  wire logic [3:0]  parity_lat,
	// data out
	output logic [7:0]       dq_out_r,
	output logic             dq_oe_n_r,
	output logic             read_dbi_r,
	// mode status
	output logic             store_en_r,
	output logic [1:0]       fmt_r,
	output logic [1:0]       page_r
);
	import sds_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001, // no read pending
		ST_WAIT  = 3'b010, // latency counting
		ST_BURST = 3'b100  // driving data
	} rd_state_e;

	rd_state_e        state_r;       // read sequencer state
	rd_state_e        state_nxt;     // next sequencer state
	logic [LAT_W-1:0] lat_cnt_r;     // latency countdown
	logic [3:0]       ui_cnt_r;      // unit interval counter
	logic [3:0]       ui_len_r;      // burst length in ui
	logic             chop_hi_r;     // chop upper half select
	logic [1:0]       rd_loc_r;      // location being read
	logic [1:0]       rd_page_r;     // page being read
	logic [7:0]       shift_r;       // outgoing location bits
	logic             rdbi_cfg_r;    // stored read inversion enable
	logic [7:0]       log0_r;        // error address low
	logic [7:0]       log1_r;        // error address high
	logic [7:0]       log2_r;        // error command and bank
	logic             crc_flag_r;    // sticky crc error
	logic             par_flag_r;    // sticky parity error
	logic [7:0]       pat_rd;        // pattern memory output

	// command decode
	wire is_mrs     = cmd_valid && (cmd_code == CMD_MRS);
	wire mrs_three  = is_mrs && (cmd_bank == MR_THREE[1:0]) && (cmd_group[0] == MR_THREE[2]);
	wire mrs_five   = is_mrs && (cmd_bank == MR_FIVE[1:0]) && (cmd_group[0] == MR_FIVE[2]);
	wire is_rd_any  = cmd_valid && ((cmd_code == CMD_RD) || (cmd_code == CMD_RDA));
	wire is_wr_any  = cmd_valid && ((cmd_code == CMD_WR) || (cmd_code == CMD_WRA));
	wire store_rd   = store_en_r && is_rd_any && (state_r == ST_IDLE);
	wire store_wr   = store_en_r && is_wr_any && (page_r == PAGE_PATTERN);
	wire [LAT_W-1:0] read_lat = LAT_W'(add_latency) + LAT_W'(cas_latency);
	// parallel uses location 0 only; other pages forced serial
	wire [1:0] cap_loc = (fmt_r == FMT_PARALLEL && page_r == PAGE_PATTERN) ? 2'h0 : cmd_bank;
	// steer the store address at the read edge so short latency sees fresh data
	wire [1:0] mem_loc = store_rd ? cap_loc : rd_loc_r;

	// vendor page: arbitrary fill, location 3 low nibble defined
	wire [7:0] vendor_byte = (rd_loc_r == 2'h3) ? {VENDOR_FILL[7:4], VENDOR_LOC3_LOW}
	                                             : VENDOR_FILL;
	// page 2 location 0 with refresh rate status in bits 4:3
	wire [7:0] setting0 = {setting_byte_0_rest, refresh_rate, setting_byte_0_low};
	wire [7:0] log3     = {crc_flag_r, par_flag_r, 2'h0, parity_lat};

	// page byte selection for the location being read
	wire [7:0] page1_byte = (rd_loc_r == 2'h0) ? log0_r :
	                        (rd_loc_r == 2'h1) ? log1_r :
	                        (rd_loc_r == 2'h2) ? log2_r : log3;
	wire [7:0] page2_byte = (rd_loc_r == 2'h0) ? setting0 :
	                        (rd_loc_r == 2'h1) ? setting_byte_1 :
	                        (rd_loc_r == 2'h2) ? setting_byte_2 : setting_byte_3;
	wire [7:0] sel_byte   = (rd_page_r == PAGE_PATTERN) ? pat_rd :
	                        (rd_page_r == PAGE_ERRLOG)  ? page1_byte :
	                        (rd_page_r == PAGE_SETTING) ? page2_byte : vendor_byte;

	// pattern store instance
	sds_pattern_mem u_mem (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.wr_en     (store_wr),
		.wr_loc    (cmd_bank),
		.wr_data   (cmd_addr[7:0]),
		.rd_loc    (mem_loc),
		.rd_data_r (pat_rd)
	);

	// mode register three fields
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			store_en_r <= 1'b0;
			fmt_r      <= FMT_SERIAL;
			page_r     <= PAGE_PATTERN;
		end else if (mrs_three) begin
			store_en_r <= cmd_addr[FLD_ENABLE];
			fmt_r      <= cmd_addr[FLD_FMT_LO +: 2];
			page_r     <= cmd_addr[FLD_PAGE_LO +: 2];
		end
	end

	// read inversion setting and its gated output
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdbi_cfg_r <= 1'b0;
			read_dbi_r <= 1'b0;
		end else begin
			if (mrs_five) begin
				rdbi_cfg_r <= cmd_addr[FLD_RDBI];
			end
			read_dbi_r <= rdbi_cfg_r && !store_en_r;
		end
	end

	// error log capture of the last errored command
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			log0_r <= 8'h00;
			log1_r <= 8'h00;
			log2_r <= 8'h00;
		end else if (err_cap) begin
			log0_r <= cmd_addr[7:0];
			log1_r <= cmd_addr[15:8];
			log2_r <= {err_par_bit, err_act_n, cmd_group, cmd_bank, cmd_addr[17:16]};
		end
	end

	// sticky error flags; a new error wins over the mode exit clear
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			crc_flag_r <= 1'b0;
			par_flag_r <= 1'b0;
		end else begin
			crc_flag_r <= crc_err || (crc_flag_r && !(mrs_three && !cmd_addr[FLD_ENABLE]));
			par_flag_r <= parity_err || (par_flag_r && !(mrs_three && !cmd_addr[FLD_ENABLE]));
		end
	end

	// read sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (store_rd) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (lat_cnt_r <= LAT_W'(1)) begin
					state_nxt = ST_BURST;
				end
			end
			ST_BURST: begin
				if (ui_cnt_r == ui_len_r - 4'h1) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// read command capture and latency count
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			lat_cnt_r <= '0;
			rd_loc_r  <= 2'h0;
			rd_page_r <= PAGE_PATTERN;
			ui_len_r  <= 4'(BURST_UI8);
			chop_hi_r <= 1'b0;
		end else if (store_rd) begin
			lat_cnt_r <= read_lat;
			rd_loc_r  <= cap_loc;
			rd_page_r <= page_r;
			ui_len_r  <= cmd_chop ? 4'(BURST_UI4) : 4'(BURST_UI8);
			chop_hi_r <= cmd_chop && cmd_addr[2];
		end else if (state_r == ST_WAIT) begin
			lat_cnt_r <= lat_cnt_r - LAT_W'(1);
		end
	end

	// burst shifter: bit 7 first, bit 3 for a chop upper half; parallel repeats the byte each ui
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ui_cnt_r  <= 4'h0;
			shift_r   <= 8'h00;
			dq_out_r  <= 8'h00;
			dq_oe_n_r <= 1'b1;
		end else if (state_nxt == ST_BURST && state_r == ST_WAIT) begin
			ui_cnt_r  <= 4'h0;
			shift_r   <= chop_hi_r ? {sel_byte[2:0], 5'h00} : {sel_byte[6:0], 1'b0};
			dq_oe_n_r <= 1'b0;
			if (fmt_r != FMT_SERIAL && rd_page_r == PAGE_PATTERN) begin
				dq_out_r <= sel_byte;
			end else begin
				dq_out_r <= {8{chop_hi_r ? sel_byte[3] : sel_byte[7]}};
			end
		end else if (state_r == ST_BURST && state_nxt == ST_BURST) begin
			ui_cnt_r <= ui_cnt_r + 4'h1;
			shift_r  <= {shift_r[6:0], 1'b0};
			if (fmt_r == FMT_SERIAL || rd_page_r != PAGE_PATTERN) begin
				dq_out_r <= {8{shift_r[7]}};
			end
		end else if (state_r == ST_BURST) begin
			dq_oe_n_r <= 1'b1;
			dq_out_r  <= 8'h00;
		end
	end

	// read inversion deasserted from the cycle after store access turns on
	property p_no_dbi;
		@(posedge sys_clk) disable iff (reset)
		store_en_r |=> !read_dbi_r;
	endproperty
	a_no_dbi: assert property (p_no_dbi) else $error("inversion in store mode");

	// write to a read-only page leaves every pattern location alone
	property p_ro_write;
		@(posedge sys_clk) disable iff (reset)
		(store_en_r && is_wr_any && page_r != PAGE_PATTERN)
		|=> ($stable(u_mem.mem_r[0]) && $stable(u_mem.mem_r[1])
		     && $stable(u_mem.mem_r[2]) && $stable(u_mem.mem_r[3]));
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("write reached ro page");

	// mode three set takes enable bit next cycle
	property p_enable;
		@(posedge sys_clk) disable iff (reset)
		mrs_three |=> (store_en_r == $past(cmd_addr[FLD_ENABLE]));
	endproperty
	a_enable: assert property (p_enable) else $error("enable bit not taken");

	// format field follows bits 12:11
	property p_fmt;
		@(posedge sys_clk) disable iff (reset)
		mrs_three |=> (fmt_r == $past(cmd_addr[12:11]));
	endproperty
	a_fmt: assert property (p_fmt) else $error("format field wrong");

	// page field follows bits 1:0
	property p_page;
		@(posedge sys_clk) disable iff (reset)
		mrs_three |=> (page_r == $past(cmd_addr[1:0]));
	endproperty
	a_page: assert property (p_page) else $error("page field wrong");

	// auto precharge read starts a burst just like a plain read
	property p_rda;
		@(posedge sys_clk) disable iff (reset)
		(store_en_r && state_r == ST_IDLE && cmd_valid && cmd_code == CMD_RDA)
		|=> (state_r == ST_WAIT);
	endproperty
	a_rda: assert property (p_rda) else $error("rda not treated as rd");

	// drive window is eight ui once started for an unchopped burst
	property p_burst_len;
		@(posedge sys_clk) disable iff (reset)
		($fell(dq_oe_n_r) && ui_len_r == 4'(BURST_UI8)) |-> !dq_oe_n_r [*8] ##1 dq_oe_n_r;
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("burst eight length");

	// chopped burst drives for exactly four ui
	property p_chop_len;
		@(posedge sys_clk) disable iff (reset)
		($fell(dq_oe_n_r) && ui_len_r == 4'(BURST_UI4)) |-> !dq_oe_n_r [*4] ##1 dq_oe_n_r;
	endproperty
	a_chop_len: assert property (p_chop_len) else $error("burst chop length");

	// serial readout puts the same bit on every lane
	property p_lanes_equal;
		@(posedge sys_clk) disable iff (reset)
		(!dq_oe_n_r && (fmt_r == FMT_SERIAL || rd_page_r != PAGE_PATTERN))
		|-> (dq_out_r == {8{dq_out_r[0]}});
	endproperty
	a_lanes_equal: assert property (p_lanes_equal) else $error("serial lanes differ");

	// no drive without a read having started
	property p_read_start;
		@(posedge sys_clk) disable iff (reset)
		$fell(dq_oe_n_r) |-> $past(state_r == ST_WAIT);
	endproperty
	a_read_start: assert property (p_read_start) else $error("drive without read");

	// a crc error always shows in the status flag
	property p_crc_flag;
		@(posedge sys_clk) disable iff (reset)
		crc_err |=> crc_flag_r;
	endproperty
	a_crc_flag: assert property (p_crc_flag) else $error("crc flag lost");
endmodule : sds_access

/* File: shared/sds_pkg.sv */
/*
 * constants for the special-data store access block: command codes,
 * mode field positions, page layout, default patterns, readout formats.
 * assumes a decoded command stream from the command/address front end.
 */
package sds_pkg;
	// decoded command codes from the command front end
	localparam logic [3:0] CMD_DES    = 4'h0;
	localparam logic [3:0] CMD_MRS    = 4'h1;
	localparam logic [3:0] CMD_RD     = 4'h2;
	localparam logic [3:0] CMD_RDA    = 4'h3;
	localparam logic [3:0] CMD_WR     = 4'h4;
	localparam logic [3:0] CMD_WRA    = 4'h5;
	localparam logic [3:0] CMD_REF    = 4'h6;
	localparam logic [3:0] CMD_RESET  = 4'h7;
	localparam logic [3:0] CMD_ACT    = 4'h8;
	localparam logic [3:0] CMD_PRE    = 4'h9;
	localparam logic [3:0] CMD_SRE    = 4'ha;
	localparam logic [3:0] CMD_PDE    = 4'hb;
	// mode register numbers carried on the bank address (bits 1:0) and bank group bit 0 (bit 2) of a set command
	localparam logic [2:0] MR_THREE   = 3'h3;
	localparam logic [2:0] MR_FIVE    = 3'h5;
	// field positions inside mode register three
	localparam int FLD_ENABLE   = 2;
	localparam int FLD_FMT_LO   = 11;
	localparam int FLD_PAGE_LO  = 0;
	// read inversion enable bit inside mode register five
	localparam int FLD_RDBI     = 12;
	// readout formats
	localparam logic [1:0] FMT_SERIAL    = 2'h0;
	localparam logic [1:0] FMT_PARALLEL  = 2'h1;
	localparam logic [1:0] FMT_STAGGERED = 2'h2;
	localparam logic [1:0] FMT_RESERVED  = 2'h3;
	// page numbers
	localparam logic [1:0] PAGE_PATTERN  = 2'h0;
	localparam logic [1:0] PAGE_ERRLOG   = 2'h1;
	localparam logic [1:0] PAGE_SETTING  = 2'h2;
	localparam logic [1:0] PAGE_VENDOR   = 2'h3;
	// page 0 defaults, locations 0 to 3
	localparam logic [7:0] PAT0_RST = 8'h55;
	localparam logic [7:0] PAT1_RST = 8'h33;
	localparam logic [7:0] PAT2_RST = 8'h0f;
	localparam logic [7:0] PAT3_RST = 8'h00;
	// refresh rate status codes in page 2 location 0 [4:3]
	localparam logic [1:0] RATE_SUB1X = 2'h0;
	localparam logic [1:0] RATE_1X    = 2'h1;
	localparam logic [1:0] RATE_2X    = 2'h2;
	localparam int RATE_LO = 3;
	// burst geometry
	localparam int BURST_UI8 = 8;
	localparam int BURST_UI4 = 4;
	// read latency counter width
	localparam int LAT_W = 6;
	// vendor page content, arbitrary value
	localparam logic [7:0] VENDOR_FILL = 8'h00;
	localparam logic [3:0] VENDOR_LOC3_LOW = 4'h0;
endpackage : sds_pkg

/* File: verilog/sds_pattern_mem.sv */
/*
 * four-byte pattern store of page 0 with registered read data.
 * assumes writes and reads come from the access block on the same clock.
 */
`timescale 1ns/100ps
module sds_pattern_mem (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// write port
	input  wire logic       wr_en,
	input  wire logic [1:0] wr_loc,
	input  wire logic [7:0] wr_data,
	// read port
	input  wire logic [1:0] rd_loc,
	output logic      [7:0] rd_data_r
);
	import sds_pkg::*;

	logic [7:0] mem_r [4]; // pattern locations

	// hold values until reset reloads the defaults
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mem_r[0] <= PAT0_RST;
			mem_r[1] <= PAT1_RST;
			mem_r[2] <= PAT2_RST;
			mem_r[3] <= PAT3_RST;
		end else if (wr_en) begin
			mem_r[wr_loc] <= wr_data;
		end
	end

	// registered read data
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rd_data_r <= 8'h00;
		end else begin
			rd_data_r <= mem_r[rd_loc];
		end
	end
endmodule : sds_pattern_mem

/* File: dv/ctrl_model.sv */
/*
 * controller-side partner: issues at most one decoded command per call, none if store mode forbids the command.
 * assumes the access block samples commands on rising sys_clk.
 */
`timescale 1ns/100ps
module ctrl_model
	import sds_pkg::*;
	#(parameter int REFRESH_CYCLE_TIME_CYC = 8)
(
	// clock and mode view
	input  wire logic        sys_clk,
	input  wire logic        store_en_r,
	// command bus
	output logic             cmd_valid,
	output logic [3:0]       cmd_code,
	output logic [17:0]      cmd_addr,
	output logic [1:0]       cmd_bank,
	output logic [1:0]       cmd_group,
	output logic             cmd_chop
);
	// idle bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_code  = CMD_DES;
		cmd_addr  = 18'h0;
		cmd_bank  = 2'h0;
		cmd_group = 2'h0;
		cmd_chop  = 1'b0;
	end
	// one command, then address, bank and group lines go to the inverse of their last value
	task automatic issue(input logic [3:0] c, input logic [17:0] a, input logic [1:0] b,
		input logic [1:0] g, input logic ch);
		logic ok;
		ok = !store_en_r || (c inside {CMD_MRS, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
			CMD_DES, CMD_REF, CMD_RESET});
		if (ok) begin
			@(posedge sys_clk);
			cmd_valid <= 1'b1;
			cmd_code  <= c;
			cmd_addr  <= ch ? {a[17:3], 3'h0} : a;
			cmd_bank  <= b;
			cmd_group <= g;
			cmd_chop  <= ch;
			@(posedge sys_clk);
			cmd_valid <= 1'b0;
			cmd_addr  <= ~cmd_addr;
			cmd_bank  <= ~cmd_bank;
			cmd_group <= ~cmd_group;
			if (c == CMD_REF) repeat (REFRESH_CYCLE_TIME_CYC) @(posedge sys_clk);
		end
	endtask : issue
endmodule : ctrl_model

/* File: dv/tb.sv */
/*
 * self-checking bench for the special-data store access block.
 * assumes ctrl_model drives commands; an integer and queue model predicts.
 */
`timescale 1ns/100ps
module tb;
	import sds_pkg::*;
	logic sys_clk = 1'b0, reset = 1'b1;
	logic cmd_valid, cmd_chop;
	logic [3:0] cmd_code;
	logic [17:0] cmd_addr;
	logic [1:0] cmd_bank, cmd_group, refresh_rate;
	logic [4:0] add_latency, cas_latency;
	logic [7:0] sb [1:3];
	logic [2:0] s0r, s0l;
	logic err_cap, err_par_bit, err_act_n, crc_err, parity_err;
	logic [3:0] parity_lat;
	logic [7:0] dq_out_r;
	logic dq_oe_n_r, read_dbi_r, store_en_r;
	logic [1:0] fmt_r, page_r;
	// model state
	logic [7:0] pat [4], elog [4];
	logic m5, crc_f, par_f;
	logic [31:0] seed = 32'h4a;
	int err_total = 0, cmp_count = 0;
	// clock
	always #25 sys_clk = ~sys_clk;
	ctrl_model ctrl_model_i (.sys_clk(sys_clk), .store_en_r(store_en_r),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
		.cmd_bank(cmd_bank), .cmd_group(cmd_group), .cmd_chop(cmd_chop));
	sds_access sds_access_i (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_bank(cmd_bank),
		.cmd_group(cmd_group), .cmd_chop(cmd_chop), .add_latency(add_latency),
		.cas_latency(cas_latency), .refresh_rate(refresh_rate),
		.setting_byte_1(sb[1]), .setting_byte_2(sb[2]), .setting_byte_3(sb[3]),
		.setting_byte_0_rest(s0r), .setting_byte_0_low(s0l), .err_cap(err_cap),
		.err_par_bit(err_par_bit), .err_act_n(err_act_n), .crc_err(crc_err),
		.parity_err(parity_err), .parity_lat(parity_lat), .dq_out_r(dq_out_r),
		.dq_oe_n_r(dq_oe_n_r), .read_dbi_r(read_dbi_r), .store_en_r(store_en_r),
		.fmt_r(fmt_r), .page_r(page_r));
	// xorshift source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// predicted byte of a page location
	function automatic logic [7:0] expv(input logic [1:0] pg, input logic [1:0] loc);
		case (pg)
			2'h0: return pat[loc];
			2'h1: return (loc == 2'h3) ? {crc_f, par_f, 2'h0, parity_lat} : elog[loc];
			2'h2: return (loc == 2'h0) ? {s0r, refresh_rate, s0l} : sb[loc];
			default: return (loc == 2'h3) ? {4'h0, VENDOR_LOC3_LOW} : VENDOR_FILL;
		endcase
	endfunction : expv
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// reset and model defaults
	task automatic do_reset();
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		pat = '{PAT0_RST, PAT1_RST, PAT2_RST, PAT3_RST};
		{m5, crc_f, par_f} = 3'h0;
		#1;
		chk({dq_oe_n_r, store_en_r, fmt_r, page_r, dq_out_r, read_dbi_r}, 15'h4000);
	endtask : do_reset
	// mode register three write and field check
	task automatic mrs3(input logic en, input logic [1:0] f, input logic [1:0] pg);
		ctrl_model_i.issue(CMD_MRS, {5'h0, f, 8'h0, en, pg}, 2'h3, 2'h0, 1'b0);
		if (!en) {crc_f, par_f} = 2'h0;
		@(posedge sys_clk);
		#1;
		chk(store_en_r, en);
		chk(fmt_r, f);
		chk(page_r, pg);
		chk(read_dbi_r, m5 & ~en);
	endtask : mrs3
	// read burst: latency, bit order, length, release
	task automatic rd(input logic [3:0] c, input logic [1:0] b, input logic ch,
		input logic [7:0] e, input logic par, input logic [7:0] m);
		int k, n;
		logic [7:0] q [$];
		n = add_latency + cas_latency;
		if (n < 1) n = 1;
		for (int i = 0; i < 8; i++) q.push_back(par ? e : {8{e[7 - i]}});
		ctrl_model_i.issue(c, 18'h0, b, 2'h0, ch);
		k = 0;
		do begin
			@(posedge sys_clk);
			#1;
			k++;
		end while (dq_oe_n_r !== 1'b0 && k < 80);
		chk(k, n);
		for (int i = 0; i < (ch ? 4 : 8); i++) begin
			if (i > 0) begin
				@(posedge sys_clk);
				#1;
			end
			chk(dq_oe_n_r, 1'b0);
			if (m[7 - i]) chk(dq_out_r, q[i]);
		end
		@(posedge sys_clk);
		#1;
		chk({dq_oe_n_r, dq_out_r}, 9'h100);
	endtask : rd
	// write with model update
	task automatic wr(input logic [3:0] c, input logic [1:0] loc, input logic [7:0] d);
		ctrl_model_i.issue(c, {10'h0, d}, loc, 2'h0, 1'b0);
		if (store_en_r && page_r == PAGE_PATTERN) pat[loc] = d;
	endtask : wr
	// watchdog
	initial begin
		#(50 * 20000);
		err_total++;
		end_sim();
	end
	// main sequence
	initial begin
		logic [17:0] a;
		logic [1:0] b, g;
		{err_cap, crc_err, parity_err} = 3'h0;
		add_latency = 5'(rnd() % 4);
		cas_latency = 5'(rnd() % 8);
		refresh_rate = 2'(rnd() % 3);
		{sb[1], sb[2], sb[3], s0r, s0l} = 30'(rnd());
		{err_par_bit, err_act_n, parity_lat} = 6'(rnd());
		do_reset();
		ctrl_model_i.issue(CMD_RD, 18'h0, 2'h0, 2'h0, 1'b0);
		repeat (14) begin
			@(posedge sys_clk);
			#1;
			chk(dq_oe_n_r, 1'b1);
		end
		ctrl_model_i.issue(CMD_MRS, 18'h1000, 2'h1, 2'h1, 1'b0);
		m5 = 1'b1;
		mrs3(1'b1, FMT_SERIAL, PAGE_PATTERN);
		for (int l = 0; l < 4; l++) rd(CMD_RD, 2'(l), 1'b0, pat[l], 1'b0, 8'hff);
		for (int l = 0; l < 4; l++) wr(l[0] ? CMD_WRA : CMD_WR, 2'(l), 8'(rnd()));
		for (int l = 0; l < 4; l++) rd(CMD_RDA, 2'(l), 1'b0, pat[l], 1'b0, 8'hff);
		rd(CMD_RD, 2'h2, 1'b1, pat[2], 1'b0, 8'hf0);
		for (int f = 1; f < 3; f++) begin
			mrs3(1'b1, 2'(f), PAGE_PATTERN);
			rd(CMD_RD, 2'h2, 1'b0, (f == 1) ? pat[0] : pat[2], 1'b1, 8'hff);
		end
		mrs3(1'b1, FMT_SERIAL, PAGE_ERRLOG);
		a = 18'(rnd());
		{b, g} = 4'(rnd());
		elog[0] = a[7:0];
		elog[1] = a[15:8];
		elog[2] = {err_par_bit, err_act_n, g, b, a[17:16]};
		fork
			ctrl_model_i.issue(CMD_DES, a, b, g, 1'b0);
			begin
				@(posedge sys_clk);
				{err_cap, crc_err, parity_err} <= 3'h7;
				@(posedge sys_clk);
				{err_cap, crc_err, parity_err} <= 3'h0;
			end
		join
		{crc_f, par_f} = 2'h3;
		wr(CMD_WR, 2'h0, 8'(~a[7:0]));
		for (int l = 0; l < 4; l++) rd(CMD_RD, 2'(l), 1'b0, expv(1, 2'(l)), 1'b0, 8'hff);
		ctrl_model_i.issue(CMD_REF, 18'h0, 2'h0, 2'h0, 1'b0);
		mrs3(1'b1, FMT_SERIAL, PAGE_SETTING);
		for (int l = 0; l < 4; l++) rd(CMD_RD, 2'(l), 1'b0, expv(2, 2'(l)), 1'b0, 8'hff);
		mrs3(1'b1, FMT_SERIAL, PAGE_VENDOR);
		rd(CMD_RD, 2'h3, 1'b0, expv(3, 2'h3), 1'b0, 8'h0f);
		mrs3(1'b0, FMT_SERIAL, PAGE_PATTERN);
		mrs3(1'b1, FMT_SERIAL, PAGE_ERRLOG);
		rd(CMD_RD, 2'h3, 1'b0, expv(1, 2'h3), 1'b0, 8'hff);
		mrs3(1'b1, FMT_SERIAL, PAGE_PATTERN);
		rd(CMD_RD, 2'h0, 1'b0, pat[0], 1'b0, 8'hff);
		do_reset();
		mrs3(1'b1, FMT_SERIAL, PAGE_PATTERN);
		rd(CMD_RD, 2'h1, 1'b0, PAT1_RST, 1'b0, 8'hff);
		end_sim();
	end
endmodule : tb
